// *** spfs_sequencer.sv ***
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Purpose: Self-programming flash sequencer with AXI4-Lite registers and table port.
// Assumes: Table port requests from the core are single-cycle strobes.
// Notes: The flash array is outside; this block drives its erase/program strobes.
module spfs_sequencer #(
  parameter int OP_CYCLES = spfs_pkg::OP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic table_req,
  input wire logic table_write,
  input wire logic table_high,
  input wire logic table_byte,
  input wire logic [15:0] operand_pointer,
  input wire logic [15:0] table_wdata,
  output logic table_ack,
  output logic [15:0] table_rdata,
  output logic cpu_stall,
  output logic flash_erase_start,
  output logic flash_program_start,
  output logic [23:0] flash_row_addr,
  output logic [23:0] latch_rd_data,
  input wire logic [4:0] latch_rd_index
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] flash_op_control;
  logic [15:0] flash_addr_low;
  logic [7:0] flash_addr_high;
  logic [7:0] table_page_register;
  spfs_pkg::spfs_key_type key_state;
  logic unlocked;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic busy;
  logic done;
  logic start_op;
  logic tbl_phase;
  logic [23:0] full_addr;
  logic [2:0] lanes;
  logic [23:0] lane_data;
  logic [4:0] last_index;
  logic order_error;

  assign full_addr = {table_page_register, operand_pointer};
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign s_axi_arready = !s_axi_rvalid;
  assign cpu_stall = busy;
  assign flash_row_addr = {flash_addr_high, flash_addr_low[15:6], 6'h00};

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_state <= spfs_pkg::SPFS_IDLE;
      unlocked <= 1'b0;
    end
    else if (do_write)
    begin
      if (aw_addr == spfs_pkg::ADDR_UNLOCK_KEY)
      begin
        case (key_state)
          spfs_pkg::SPFS_IDLE:
          begin
            unlocked <= 1'b0;
            if (w_data[15:0] == spfs_pkg::KEY_FIRST)
            begin
              key_state <= spfs_pkg::SPFS_ARMED;
            end
          end
          default:
          begin
            key_state <= spfs_pkg::SPFS_IDLE;
            unlocked <= (w_data[15:0] == spfs_pkg::KEY_SECOND);
          end
        endcase
      end
      else if (aw_addr == spfs_pkg::ADDR_OP_CONTROL && w_data[spfs_pkg::GO_BIT])
      begin
        key_state <= spfs_pkg::SPFS_IDLE;
        unlocked <= 1'b0;
      end
      else
      begin
        key_state <= spfs_pkg::SPFS_IDLE;
        unlocked <= unlocked && (aw_addr != spfs_pkg::ADDR_OP_CONTROL) && key_state == spfs_pkg::SPFS_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and operation start
  // ----------------------------------------------------------------
  assign start_op = do_write && aw_addr == spfs_pkg::ADDR_OP_CONTROL && w_data[spfs_pkg::GO_BIT]
    && w_data[spfs_pkg::PERMIT_BIT] && unlocked && !busy;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_op_control <= spfs_pkg::CONTROL_RESET;
    end
    else if (do_write && aw_addr == spfs_pkg::ADDR_OP_CONTROL && !busy)
    begin
      flash_op_control <= {start_op, w_data[14:0]};
    end
    else if (done)
    begin
      flash_op_control[spfs_pkg::GO_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_erase_start <= 1'b0;
      flash_program_start <= 1'b0;
    end
    else
    begin
      flash_erase_start <= start_op && w_data[spfs_pkg::ERASE_BIT];
      flash_program_start <= start_op && !w_data[spfs_pkg::ERASE_BIT];
    end
  end

  spfs_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_op),
    .busy(busy),
    .done(done)
  );

  // ----------------------------------------------------------------
  // Address registers and table page
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_addr_low <= 16'h0000;
      flash_addr_high <= 8'h00;
      table_page_register <= 8'h00;
    end
    else if (table_req && !tbl_phase && !busy)
    begin
      flash_addr_low <= full_addr[15:0];
      flash_addr_high <= full_addr[23:16];
    end
    else if (do_write && !busy)
    begin
      if (aw_addr == spfs_pkg::ADDR_ADDR_LOW)
      begin
        flash_addr_low <= w_data[15:0];
      end
      else if (aw_addr == spfs_pkg::ADDR_ADDR_HIGH)
      begin
        flash_addr_high <= w_data[7:0];
      end
      else if (aw_addr == spfs_pkg::ADDR_TABLE_PAGE)
      begin
        table_page_register <= w_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Table port: latch writes and reads
  // ----------------------------------------------------------------
  always_comb
  begin
    lanes = 3'h0;
    lane_data = {table_wdata[7:0], table_wdata};
    if (table_high)
    begin
      lanes = 3'h4;
    end
    else if (table_byte)
    begin
      lanes = operand_pointer[0] ? 3'h2 : 3'h1;
      lane_data = {table_wdata[7:0], table_wdata[7:0], table_wdata[7:0]};
    end
    else
    begin
      lanes = 3'h3;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tbl_phase <= 1'b0;
      table_ack <= 1'b0;
      last_index <= 5'h00;
      order_error <= 1'b0;
    end
    else
    begin
      table_ack <= 1'b0;
      if (table_req && !tbl_phase && !busy)
      begin
        tbl_phase <= 1'b1;
        if (table_write && !table_high && operand_pointer[5:1] == 5'h00)
        begin
          order_error <= 1'b0;
        end
        else if (table_write && !table_high && operand_pointer[5:1] != last_index + 5'h01)
        begin
          order_error <= 1'b1;
        end
        if (table_write && table_high)
        begin
          last_index <= operand_pointer[5:1];
        end
      end
      else if (tbl_phase)
      begin
        tbl_phase <= 1'b0;
        table_ack <= 1'b1;
      end
    end
  end

  spfs_row_latch #(
    .WORDS(spfs_pkg::ROW_WORDS),
    .AW(5)
  ) u_latch (
    .aclk(aclk),
    .wr_index(operand_pointer[5:1]),
    .wr_lane((table_req && table_write && !tbl_phase && !busy) ? lanes : 3'h0),
    .wr_data(lane_data),
    .rd_index(tbl_phase ? flash_addr_low[5:1] : latch_rd_index),
    .rd_data(latch_rd_data)
  );

  always_comb
  begin
    table_rdata = table_high ? {8'h00, latch_rd_data[23:16]} : latch_rd_data[15:0];
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == spfs_pkg::ADDR_OP_CONTROL)
      begin
        s_axi_rdata <= {16'h0000, flash_op_control};
      end
      else if (s_axi_araddr == spfs_pkg::ADDR_ADDR_LOW)
      begin
        s_axi_rdata <= {16'h0000, flash_addr_low};
      end
      else if (s_axi_araddr == spfs_pkg::ADDR_ADDR_HIGH)
      begin
        s_axi_rdata <= {24'h00_0000, flash_addr_high};
      end
      else if (s_axi_araddr == spfs_pkg::ADDR_TABLE_PAGE)
      begin
        s_axi_rdata <= {24'h00_0000, table_page_register};
      end
      else if (s_axi_araddr == spfs_pkg::ADDR_STATUS)
      begin
        s_axi_rdata <= {29'h0000_0000, order_error, unlocked, busy};
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // spfs_sequencer

// *** spfs_pkg.sv ***
// Purpose: Constants for the self-programming flash sequencer.
// Assumes: AXI4-Lite register access, 100 MHz clock.
// Notes: Register offsets are byte addresses of aligned words.
package spfs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OP_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'h04;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h08;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] ADDR_TABLE_PAGE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int GO_BIT = 15;
  localparam int PERMIT_BIT = 14;
  localparam int ERASE_BIT = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  localparam int ROW_WORDS = 32;
  localparam int PANEL_ROWS = 128;
  localparam int WORD_BITS = 24;
  localparam int TABLE_WRITE_CYCLES = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * CLOCK_MHZ;
  typedef enum logic [1:0] {SPFS_IDLE, SPFS_ARMED} spfs_key_type;
endpackage

// *** spfs_row_latch.sv ***
`timescale 1ns/1ps
// Purpose: Row write latches, one 24-bit word per instruction slot.
// Assumes: Byte enables per lane; registered read data.
// Notes: Upper byte holds bits 23..16 of the instruction.
module spfs_row_latch #(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  input wire logic aclk,
  input wire logic [AW-1:0] wr_index,
  input wire logic [2:0] wr_lane,
  input wire logic [23:0] wr_data,
  input wire logic [AW-1:0] rd_index,
  output logic [23:0] rd_data
);
  logic [23:0] mem [WORDS];

  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (wr_lane[i])
      begin
        mem[wr_index][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    rd_data <= mem[rd_index];
  end
endmodule // spfs_row_latch

// *** spfs_op_timer.sv ***
`timescale 1ns/1ps
// Purpose: Counts the length of one erase or program cycle.
// Assumes: One start pulse per operation.
// Notes: Done is a one-cycle pulse at the end of the count.
module spfs_op_timer #(
  parameter int CYCLES = 200000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [31:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      count <= 32'h0000_0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        count <= 32'(CYCLES - 1);
      end
      else if (busy)
      begin
        if (count == 32'h0000_0000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          count <= count - 32'h0000_0001;
        end
      end
    end
  end
endmodule // spfs_op_timer

// *** spfs_sequencer_assertions.sv ***
// Purpose: Port-level assertions for spfs_sequencer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Stall length is counted in helper logic, not unrolled.
`timescale 1ns/1ps
module spfs_chk #(
  parameter int OP_CYCLES = spfs_pkg::OP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic table_req,
  input wire logic table_ack,
  input wire logic cpu_stall,
  input wire logic flash_erase_start,
  input wire logic flash_program_start,
  input wire logic [23:0] flash_row_addr
);
  int unsigned stall_len;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Helper
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cpu_stall)
    begin
      stall_len <= 0;
    end
    else
    begin
      stall_len <= stall_len + 1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ack; table_req && !cpu_stall |-> ##2 table_ack; endproperty
  a_ack: assert property (p_ack) else $error("table ack late");
  property p_ack_cause; table_ack |-> $past(table_req, 2); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_refuse; cpu_stall && $past(cpu_stall) && table_req |-> ##2 !table_ack; endproperty
  a_refuse: assert property (p_refuse) else $error("table access during stall");
  property p_len; $fell(cpu_stall) |-> stall_len == OP_CYCLES; endproperty
  a_len: assert property (p_len) else $error("stall length wrong");
  property p_start_stall; flash_erase_start || flash_program_start |-> ##[0:2] cpu_stall;
  endproperty
  a_start_stall: assert property (p_start_stall) else $error("start without stall");
  property p_row_align; flash_row_addr[5:0] == 6'h00; endproperty
  a_row_align: assert property (p_row_align) else $error("row address unaligned");
  property p_hold_addr; cpu_stall && $past(cpu_stall) |-> $stable(flash_row_addr); endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("row moved in operation");
  property p_rvalid; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read data dropped");
endmodule // spfs_chk

// *** spfs_core_model.sv ***
// Purpose: Processor core model issuing table reads and writes.
// Assumes: Each request starts right after a rising edge.
// Notes: Byte mode is raised only by the byte task, for one low write.
`timescale 1ns/1ps
module spfs_core_model (
  input wire logic aclk,
  input wire logic table_ack,
  input wire logic [15:0] table_rdata,
  output logic table_req,
  output logic table_write,
  output logic table_high,
  output logic table_byte,
  output logic [15:0] operand_pointer,
  output logic [15:0] table_wdata
);
  initial
  begin
    table_req = 1'b0;
    table_write = 1'b0;
    table_high = 1'b0;
    table_byte = 1'b0;
    operand_pointer = 16'h0000;
    table_wdata = 16'h0000;
  end
  // The strobe lasts one cycle; data turns over after the answer so stale data never matches.
  task automatic tbl(input logic w, input logic h, input logic [15:0] p, input logic [15:0] d,
    output logic got, output logic [15:0] rd);
    begin
      got = 1'b0;
      rd = 16'h0000;
      // A free edge first, so a back-to-back call never re-drives in one time step.
      @(posedge aclk);
      table_req <= 1'b1;
      table_write <= w;
      table_high <= h;
      operand_pointer <= p;
      table_wdata <= d;
      for (int n = 0; n < 4 && !got; n++)
      begin
        @(negedge aclk);
        if (table_ack === 1'b1)
        begin
          got = 1'b1;
          rd = table_rdata;
        end
        @(posedge aclk);
        table_req <= 1'b0;
      end
      table_wdata <= ~d;
    end
  endtask
  task automatic tbl_byte(input logic [15:0] p, input logic [7:0] d, output logic got);
    logic [15:0] rd;
    begin
      table_byte <= 1'b1;
      tbl(1'b1, 1'b0, p, {8'h00, d}, got, rd);
      table_byte <= 1'b0;
    end
  endtask
endmodule // spfs_core_model

// *** spfs_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for spfs_sequencer.
// Assumes: Operation length shortened to OPC cycles.
// Notes: Ready and valid are sampled at the falling edge before the taking edge.
`timescale 1ns/1ps
module spfs_sequencer_tb_top;
  localparam int OPC = 50;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic table_req, table_write, table_high, table_byte, table_ack, cpu_stall, got;
  logic [15:0] operand_pointer, table_wdata, table_rdata, rd;
  logic flash_erase_start, flash_program_start;
  logic [23:0] flash_row_addr, latch_rd_data;
  logic [4:0] latch_rd_index;
  int fails, tests_run, cyc, n_er, n_pr, x_er, x_pr;
  spfs_sequencer #(.OP_CYCLES(OPC)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .table_req, .table_write, .table_high,
    .table_byte, .operand_pointer, .table_wdata, .table_ack, .table_rdata, .cpu_stall,
    .flash_erase_start, .flash_program_start, .flash_row_addr, .latch_rd_data, .latch_rd_index);
  spfs_core_model u_core (.aclk, .table_ack, .table_rdata, .table_req, .table_write,
    .table_high, .table_byte, .operand_pointer, .table_wdata);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Timeout ceiling of 20000 cycles is many times the expected run of about a thousand cycles.
  always @(negedge aclk)
  begin
    cyc++;
    if (flash_erase_start === 1'b1)
      n_er++;
    if (flash_program_start === 1'b1)
      n_pr++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      tests_run++;
      if (g !== e)
      begin
        fails++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd, bd;
    logic [1:0] br;
    begin
      {ad, wd, bd} = 3'b000;
      br = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!bd)
      begin
        @(negedge aclk);
        {ad, wd, bd} = {ad | s_axi_awready, wd | s_axi_wready, s_axi_bvalid === 1'b1};
        br = s_axi_bresp;
        @(posedge aclk);
        s_axi_awvalid <= !ad;
        s_axi_wvalid <= !wd;
        s_axi_bready <= !bd;
      end
      chk(br, 32'h0000_0000);
    end
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    logic ad, dd;
    logic [1:0] rr;
    begin
      {ad, dd} = 2'b00;
      rr = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (!dd)
      begin
        @(negedge aclk);
        {ad, dd} = {ad | s_axi_arready, s_axi_rvalid === 1'b1};
        d = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        s_axi_arvalid <= !ad;
        s_axi_rready <= !dd;
      end
      chk(rr, 32'h0000_0000);
    end
  endtask
  // Unlock sequence; mid puts a stray write between the two keys.
  task automatic op(input logic [15:0] c, input logic [15:0] k2, input bit mid, input int e,
    input int p);
    begin
      x_er += e;
      x_pr += p;
      wr(8'h00, {16'h0000, c});
      wr(8'h0C, 32'h0000_0055);
      if (mid)
        wr(8'h04, 32'h0000_6000);
      wr(8'h0C, {16'h0000, k2});
      rdr(8'h14, r);
      chk(r[1], k2 == 16'h00AA && !mid);
      wr(8'h00, {16'h0000, c | 16'h8000});
      if (e + p > 0)
      begin
        rdr(8'h00, r);
        chk(r[15], 1);
        u_core.tbl(1'b1, 1'b0, 16'h6000, 16'h0000, got, rd);
        chk(got, 0);
        for (int n = 0; n < OPC + 20; n++)
        begin
          @(negedge aclk);
          if (cpu_stall === 1'b0)
            break;
        end
        @(posedge aclk);
      end
      else
        repeat (OPC) @(posedge aclk);
      @(negedge aclk);
      chk(cpu_stall, 0);
      @(posedge aclk);
      rdr(8'h00, r);
      chk(r[15], 0);
      chk(n_er, x_er);
      chk(n_pr, x_pr);
    end
  endtask
  task automatic results();
    begin
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    s_axi_wstrb = 4'hF;
    latch_rd_index = 5'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(8'h00, r);
    chk(r, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0055);
    rdr(8'h0C, r);
    chk(r, 32'h0000_0000);
    $display("done: reset and key");
    wr(8'h04, 32'h0000_1234);
    wr(8'h08, 32'h0000_0056);
    rdr(8'h04, r);
    chk(r, 32'h0000_1234);
    rdr(8'h08, r);
    chk(r, 32'h0000_0056);
    @(negedge aclk);
    chk(flash_row_addr, 24'h561200);
    @(posedge aclk);
    $display("done: direct address");
    wr(8'h10, 32'h0000_0012);
    for (int i = 0; i < 32; i++)
    begin
      u_core.tbl(1'b1, 1'b0, 16'(16'h6000 + 2 * i), 16'(16'hA000 + i), got, rd);
      chk(got, 1);
      u_core.tbl(1'b1, 1'b1, 16'(16'h6000 + 2 * i), 16'(16'h0030 + i), got, rd);
      chk(got, 1);
    end
    rdr(8'h04, r);
    chk(r, 32'h0000_603E);
    rdr(8'h08, r);
    chk(r, 32'h0000_0012);
    @(negedge aclk);
    chk(flash_row_addr, 24'h126000);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge aclk);
      latch_rd_index <= 5'(i);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(latch_rd_data, {8'(8'h30 + i), 16'(16'hA000 + i)});
    end
    @(posedge aclk);
    u_core.tbl(1'b0, 1'b0, 16'h600A, 16'h0000, got, rd);
    chk(rd, 16'hA005);
    u_core.tbl(1'b0, 1'b1, 16'h600A, 16'h0000, got, rd);
    chk(rd[7:0], 8'h35);
    rdr(8'h14, r);
    chk(r, 32'h0000_0000);
    u_core.tbl_byte(16'h600B, 8'h5A, got);
    chk(got, 1);
    u_core.tbl(1'b0, 1'b0, 16'h600A, 16'h0000, got, rd);
    chk(rd, 16'h5A05);
    rdr(8'h14, r);
    chk(r[2], 1);
    $display("done: latch load");
    op(16'h4000, 16'h00AA, 1'b0, 0, 1);
    op(16'h4040, 16'h00AA, 1'b0, 1, 0);
    op(16'h4040, 16'h0012, 1'b0, 0, 0);
    op(16'h4040, 16'h00AA, 1'b1, 0, 0);
    op(16'h0040, 16'h00AA, 1'b0, 0, 0);
    $display("done: operations");
    results();
  end
endmodule // spfs_sequencer_tb_top
bind spfs_sequencer spfs_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (.aclk, .aresetn, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .table_req, .table_ack, .cpu_stall, .flash_erase_start,
  .flash_program_start, .flash_row_addr);
